// ---- logic/acc_pkg.sv ----
// Functional notes
// - Bypass set, idle clear: data passes unchanged.
// - Bypass slots: 8 bits compress, 4 expand.
// - Law bit per channel: 0 A-law, 1 mu-law.
// - Normal: direction 0 expands, 1 compresses.
// - Side bit routes bytes: 1 X, 0 Y.
// - Command low six bits hold device address.
// - Rate select: 000=32k, 111=24k, 101=16k.
// - Idle bit disables channel, output tri-stated.
// - Algorithm reinit bit restarts channel algorithm.
// - Input slot register: six-bit input slot.
// - Output slot register: six-bit output slot.
// - Slot width from direction, count adds law.
// - Compress mu-law: 32x8 in, 64x4 out.
// - Rate selection never changes slot organisation.
// - Counting starts first rising edge after sync.
// - Strap low: port off, registers cleared, slot 0.
// - Hardware mode maps pins onto control bits.
// - Power-up completes within 800ms after wake.
// - Accept bytes only when address matches straps.
// - Transfers are two or four bytes.
// - Serial bits LSB first, rising edge, select low.
// - Reinit bit self-clears when reinit completes.
package acc_pkg;

  // ----------------------------------------------------------------
  // Command byte and register fields
  // ----------------------------------------------------------------
  localparam int          ACB_ADDR_MSB = 5;
  localparam int          ACB_SIDE_BIT = 6;
  localparam int          CR_DIR       = 0;
  localparam int          CR_AS2       = 1;
  localparam int          CR_LAW       = 2;
  localparam int          CR_BYP       = 3;
  localparam int          CR_ALR       = 4;
  localparam int          CR_IDLE      = 5;
  localparam int          CR_AS1       = 6;
  localparam int          CR_AS0       = 7;
  localparam int          SLOT_MSB     = 5;
  localparam logic [7:0]  CR_RESET     = 8'h20;
  localparam logic [5:0]  SLOT_RESET   = 6'h00;
  localparam int          SIDE_Y       = 0;
  localparam int          SIDE_X       = 1;

  // ----------------------------------------------------------------
  // Serial port framing
  // ----------------------------------------------------------------
  localparam logic [2:0]  NB_SHORT     = 3'h2;
  localparam logic [2:0]  NB_LONG      = 3'h4;
  localparam logic [2:0]  NB_BAD       = 3'h7;
  localparam logic [5:0]  SER_FULL     = 6'h20;
  localparam logic [5:0]  SER_OVER     = 6'h21;

  // ----------------------------------------------------------------
  // Slot organisation
  // ----------------------------------------------------------------
  localparam logic [6:0]  SLOTS_MU_PCM   = 7'h20;
  localparam logic [6:0]  SLOTS_MU_ADPCM = 7'h40;
  localparam logic [6:0]  SLOTS_A_PCM    = 7'h20;
  localparam logic [6:0]  SLOTS_A_ADPCM  = 7'h40;
  localparam logic [9:0]  BITCNT_IDLE    = 10'h3FF;
  localparam logic [2:0]  LAST_BIT_W8    = 3'h7;
  localparam logic [2:0]  LAST_BIT_W4    = 3'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          SYS_CLK_MHZ    = 125;
  localparam int          REINIT_TIME_NS = 1000;
  localparam int          REINIT_CYCLES  = (REINIT_TIME_NS * SYS_CLK_MHZ) / 1000;
  localparam int          PWRUP_TIME_MS  = 800;
  localparam int          PWRUP_CYCLES   = PWRUP_TIME_MS * SYS_CLK_MHZ * 1000;
  localparam logic [1:0]  STRAP_CATCH    = 2'h3;

  typedef enum logic [1:0] {
    RATE_32  = 2'b00,
    RATE_24  = 2'b01,
    RATE_16  = 2'b10,
    RATE_BAD = 2'b11
  } acc_rate_e;

  typedef enum logic [1:0] {
    CP_IDLE  = 2'b00,
    CP_BUSY  = 2'b01,
    CP_APPLY = 2'b10
  } acc_cp_state_e;

endpackage

// ---- logic/acc_top.sv ----
`timescale 1ns/10ps
module acc_top #(
  parameter int P_PWRUP_CYCLES = acc_pkg::PWRUP_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_cfg_sclk,
  input  wire logic              i_cfg_serial_in,
  input  wire logic              i_cfg_cs_n,
  input  wire logic [5:0]        i_dev_addr,
  input  wire logic              i_port_mode_strap,
  input  wire logic              i_side_x_bitclk,
  input  wire logic              i_side_x_framesync,
  input  wire logic              i_side_x_input,
  input  wire logic              i_side_y_bitclk,
  input  wire logic              i_side_y_framesync,
  input  wire logic              i_side_y_input,
  input  wire logic [1:0]        i_engine_out_bit,
  output logic                   o_side_x_output,
  output logic                   o_side_x_output_oe,
  output logic                   o_side_y_output,
  output logic                   o_side_y_output_oe,
  output logic [1:0]             o_coding_direction,
  output logic [1:0]             o_law_mu,
  output logic [1:0]             o_passthru_sel,
  output logic [1:0]             o_idle_powerdown,
  output logic [1:0]             o_algo_reinit,
  output acc_pkg::acc_rate_e     o_rate_x,
  output acc_pkg::acc_rate_e     o_rate_y,
  output logic [1:0]             o_engine_in_bit,
  output logic [1:0]             o_engine_in_valid,
  output logic [1:0]             o_engine_out_req,
  output logic                   o_engine_ready,
  output logic                   o_standby
);
  import acc_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic acc_rate_e rate_of(input logic [7:0] cr);
    logic [2:0] sel;
    sel = {cr[CR_AS2], cr[CR_AS1], cr[CR_AS0]};
    case (sel)
      3'h0:    rate_of = RATE_32;
      3'h7:    rate_of = RATE_24;
      3'h5:    rate_of = RATE_16;
      default: rate_of = RATE_BAD;
    endcase
  endfunction

  function automatic logic [6:0] slot_count(input logic w8, input logic mu);
    if (w8) begin
      slot_count = mu ? SLOTS_MU_PCM : SLOTS_A_PCM;
    end else begin
      slot_count = mu ? SLOTS_MU_ADPCM : SLOTS_A_ADPCM;
    end
  endfunction

  // ----------------------------------------------------------------
  // Serial port, configuration clock domain
  // ----------------------------------------------------------------
  // The captured bytes are read by the system domain only after chip
  // select has been seen high through its synchroniser; the host keeps
  // the serial clock still then, so the bytes are stable when read.
  logic [5:0]  sbit_q;
  logic [31:0] sshift_q;
  logic [2:0]  snbytes_q;
  logic [2:0]  snbytes_d;
  wire  [5:0]  sbit_d     = (sbit_q == SER_OVER) ? sbit_q : 6'(sbit_q + 6'h01);
  wire  [2:0]  sbyte_done = 3'(sbit_q[5:3] + 3'h1);

  always_comb begin
    snbytes_d = snbytes_q;
    if (sbit_q >= SER_FULL) begin
      snbytes_d = NB_BAD;
    end else if (sbit_q[2:0] == 3'h7) begin
      snbytes_d = sbyte_done;
    end else if (sbit_q == 6'h00) begin
      snbytes_d = 3'h0;
    end
  end

  always_ff @(posedge i_cfg_sclk or posedge i_rst or posedge i_cfg_cs_n) begin
    if (i_rst || i_cfg_cs_n) begin
      sbit_q <= 6'h00;
    end else begin
      sbit_q <= sbit_d;
    end
  end

  always_ff @(posedge i_cfg_sclk or posedge i_rst) begin
    if (i_rst) begin
      sshift_q  <= 32'h0000_0000;
      snbytes_q <= 3'h0;
    end else if (!i_cfg_cs_n) begin
      if (sbit_q < SER_FULL) begin
        sshift_q[sbit_q[4:0]] <= i_cfg_serial_in;
      end
      snbytes_q <= snbytes_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers, system clock domain
  // ----------------------------------------------------------------
  localparam int NSYNC = 15;
  // Chip select and the mode strap leave reset at their idle levels. A zero there would
  // look like a frame start or a spell of hardware mode, and would wipe the control bits.
  localparam logic [NSYNC-1:0] SYNC_IDLE = {1'b1, 1'b0, 1'b1, {(NSYNC-3){1'b0}}};
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  wire  [NSYNC-1:0] pins_a = {i_cfg_cs_n, i_cfg_serial_in, i_port_mode_strap, i_dev_addr,
                              i_side_x_bitclk, i_side_y_bitclk, i_side_x_framesync,
                              i_side_y_framesync, i_side_x_input, i_side_y_input};

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else begin
      meta_q <= pins_a;
      sync_q <= meta_q;
    end
  end

  wire       cs_n_s    = sync_q[14];
  wire       sdi_s     = sync_q[13];
  wire       port_mode = sync_q[12];
  wire [5:0] addr_s    = sync_q[11:6];
  wire [1:0] bclk_s    = sync_q[5:4];
  wire [1:0] fs_s      = sync_q[3:2];
  wire [1:0] din_s     = sync_q[1:0];
  wire       hw_mode   = ~port_mode;

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  acc_cp_state_e cp_q;
  acc_cp_state_e cp_d;

  always_comb begin
    cp_d = cp_q;
    case (cp_q)
      CP_IDLE:  if (!cs_n_s && port_mode) cp_d = CP_BUSY;
      CP_BUSY:  if (cs_n_s) cp_d = CP_APPLY;
      CP_APPLY: cp_d = CP_IDLE;
      default:  cp_d = CP_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cp_q <= CP_IDLE;
    end else begin
      cp_q <= cp_d;
    end
  end

  wire [7:0] acb_byte  = sshift_q[7:0];
  wire [7:0] ctl_byte  = sshift_q[15:8];
  wire [7:0] in_byte   = sshift_q[23:16];
  wire [7:0] out_byte  = sshift_q[31:24];
  wire       addr_hit  = (acb_byte[ACB_ADDR_MSB:0] == addr_s);
  wire       len_ok    = (snbytes_q == NB_SHORT) || (snbytes_q == NB_LONG);
  wire       apply_ok  = (cp_q == CP_APPLY) && addr_hit && len_ok && port_mode;
  wire       side_sel  = acb_byte[ACB_SIDE_BIT];
  wire       long_xfer = (snbytes_q == NB_LONG);
  wire       cfg_busy  = (cp_q == CP_BUSY);

  // ----------------------------------------------------------------
  // Hardware-mode rate strap
  // ----------------------------------------------------------------
  // The low level of the rate pins is latched a few cycles after reset release,
  // once their synchronisers hold real pin levels; their high level is followed live.
  logic [1:0] catch_q;
  logic       rate_low_q;
  wire        rate_pins_hi = addr_s[1] & addr_s[4];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      catch_q    <= 2'h0;
      rate_low_q <= 1'b0;
    end else if (catch_q != STRAP_CATCH) begin
      catch_q    <= 2'(catch_q + 2'h1);
      rate_low_q <= ~addr_s[1] & ~addr_s[4];
    end
  end

  wire       hw_as2 = rate_pins_hi;
  wire       hw_as1 = rate_pins_hi & rate_low_q;
  wire       hw_as0 = rate_pins_hi;
  wire [7:0] hw_cr_x = {hw_as0, hw_as1, sync_q[14], 1'b0, 1'b0, addr_s[2], hw_as2, addr_s[0]};
  wire [7:0] hw_cr_y = {hw_as0, hw_as1, sdi_s, 1'b0, 1'b0, addr_s[5], hw_as2, addr_s[3]};

  // ----------------------------------------------------------------
  // Per-channel registers and slot engines
  // ----------------------------------------------------------------
  logic [7:0] eff_q   [2];
  logic       dout_q  [2];
  logic       oe_q    [2];
  logic [1:0] in_bit_q;
  logic [1:0] in_val_q;
  logic [1:0] out_req_q;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : gen_ch
      logic [7:0] ctrl_q;
      logic [7:0] ctrl_d;
      logic [5:0] islot_q;
      logic [5:0] oslot_q;
      logic [7:0] ri_cnt_q;
      logic [9:0] cnt_q;
      logic       pend_q;
      logic       bclk_p_q;
      logic [7:0] in_sr_q;
      logic [7:0] hold_q;

      wire       wr_ctrl  = apply_ok && (side_sel == 1'(c));
      wire       wr_slot  = wr_ctrl && long_xfer;
      wire       ri_done  = ctrl_q[CR_ALR] && (ri_cnt_q == 8'(REINIT_CYCLES - 1));
      wire [7:0] hw_cr    = (c == SIDE_X) ? hw_cr_x : hw_cr_y;

      always_comb begin
        ctrl_d = ctrl_q;
        if (hw_mode) begin
          ctrl_d = 8'h00;
        end else if (wr_ctrl) begin
          ctrl_d = ctl_byte;
        end else if (ri_done) begin
          ctrl_d[CR_ALR] = 1'b0;
        end
      end

      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          ctrl_q   <= CR_RESET;
          islot_q  <= SLOT_RESET;
          oslot_q  <= SLOT_RESET;
          ri_cnt_q <= 8'h00;
          eff_q[c] <= CR_RESET;
        end else begin
          ctrl_q   <= ctrl_d;
          if (hw_mode) begin
            islot_q <= SLOT_RESET;
            oslot_q <= SLOT_RESET;
          end else if (wr_slot) begin
            islot_q <= in_byte[SLOT_MSB:0];
            oslot_q <= out_byte[SLOT_MSB:0];
          end
          if (wr_ctrl || !ctrl_q[CR_ALR] || ri_done) begin
            ri_cnt_q <= 8'h00;
          end else begin
            ri_cnt_q <= 8'(ri_cnt_q + 8'h01);
          end
          eff_q[c] <= hw_mode ? hw_cr : ctrl_q;
        end
      end

      // Slot timing; the rate bits take no part in it.
      wire       dir    = eff_q[c][CR_DIR];
      wire       mu     = eff_q[c][CR_LAW];
      wire       idle   = eff_q[c][CR_IDLE];
      wire       passthru_sel    = eff_q[c][CR_BYP] & ~idle;
      wire       in_w8  = dir;
      wire       out_w8 = passthru_sel ? dir : ~dir;
      wire       rise   = bclk_s[c] & ~bclk_p_q;
      wire       fall   = ~bclk_s[c] & bclk_p_q;
      wire       live   = ~cnt_q[9];
      // The output shows the bit that starts at this rise, so it is placed by the count
      // that this rise loads; the old count would put every output bit one period late.
      wire [9:0] cnt_nx  = pend_q ? 10'h000 : (live ? 10'(cnt_q + 10'h001) : cnt_q);
      wire       live_nx = ~cnt_nx[9];
      wire [5:0] in_idx  = in_w8 ? cnt_q[8:3] : cnt_q[7:2];
      wire [5:0] out_idx = out_w8 ? cnt_nx[8:3] : cnt_nx[7:2];
      wire [2:0] in_pos  = in_w8 ? cnt_q[2:0] : {1'b0, cnt_q[1:0]};
      wire [2:0] out_pos = out_w8 ? cnt_nx[2:0] : {1'b0, cnt_nx[1:0]};
      wire [2:0] in_last = in_w8 ? LAST_BIT_W8 : LAST_BIT_W4;
      wire [2:0] out_top = out_w8 ? LAST_BIT_W8 : LAST_BIT_W4;
      wire       in_hit  = live && (in_w8 || !cnt_q[8]) && (in_idx == islot_q)
                           && ({1'b0, in_idx} < slot_count(in_w8, mu));
      wire       out_hit = live_nx && (out_w8 || !cnt_nx[8]) && (out_idx == oslot_q)
                           && ({1'b0, out_idx} < slot_count(out_w8, mu));
      wire [2:0] hold_ix = 3'(out_top - out_pos);
      wire [7:0] in_next = {in_sr_q[6:0], din_s[c]};

      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          cnt_q        <= BITCNT_IDLE;
          pend_q       <= 1'b0;
          bclk_p_q     <= 1'b0;
          in_sr_q      <= 8'h00;
          hold_q       <= 8'h00;
          dout_q[c]    <= 1'b0;
          oe_q[c]      <= 1'b0;
          in_bit_q[c]  <= 1'b0;
          in_val_q[c]  <= 1'b0;
          out_req_q[c] <= 1'b0;
        end else begin
          bclk_p_q     <= bclk_s[c];
          in_val_q[c]  <= 1'b0;
          out_req_q[c] <= 1'b0;
          if (rise) begin
            pend_q <= fs_s[c];
            if (pend_q) begin
              cnt_q <= 10'h000;
            end else if (live) begin
              cnt_q <= 10'(cnt_q + 10'h001);
            end
            if (out_hit && !idle && !cfg_busy) begin
              oe_q[c]      <= 1'b1;
              dout_q[c]    <= passthru_sel ? hold_q[hold_ix] : i_engine_out_bit[c];
              out_req_q[c] <= ~passthru_sel;
            end else begin
              oe_q[c] <= 1'b0;
            end
          end
          if (fall && in_hit && !idle) begin
            in_sr_q     <= in_next;
            in_bit_q[c] <= din_s[c];
            in_val_q[c] <= ~passthru_sel;
            if (in_pos == in_last) begin
              hold_q <= in_next;
            end
          end
          if (idle || cfg_busy) begin
            oe_q[c] <= 1'b0;
          end
        end
      end

      assign o_coding_direction[c] = dir;
      assign o_law_mu[c]           = mu;
      assign o_passthru_sel[c]     = passthru_sel;
      assign o_idle_powerdown[c]   = idle;
      assign o_algo_reinit[c]      = eff_q[c][CR_ALR];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Power-up after leaving idle
  // ----------------------------------------------------------------
  logic [1:0]  idle_p_q;
  logic [26:0] pw_cnt_q;
  logic        pw_busy_q;
  logic        ready_q;
  wire  [1:0]  idle_now = {eff_q[SIDE_X][CR_IDLE], eff_q[SIDE_Y][CR_IDLE]};
  wire         wake     = |(idle_p_q & ~idle_now);
  wire         pw_last  = (pw_cnt_q == 27'(P_PWRUP_CYCLES - 1));

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_p_q  <= 2'h3;
      pw_cnt_q  <= 27'h0;
      pw_busy_q <= 1'b0;
      ready_q   <= 1'b0;
    end else begin
      idle_p_q <= idle_now;
      if (wake) begin
        pw_cnt_q  <= 27'h0;
        pw_busy_q <= 1'b1;
      end else if (pw_busy_q) begin
        pw_cnt_q  <= 27'(pw_cnt_q + 27'h1);
        pw_busy_q <= ~pw_last;
      end
      ready_q <= ~pw_busy_q & ~wake & ~(&idle_now);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_side_x_output    = dout_q[SIDE_X];
  assign o_side_x_output_oe = oe_q[SIDE_X];
  assign o_side_y_output    = dout_q[SIDE_Y];
  assign o_side_y_output_oe = oe_q[SIDE_Y];
  assign o_rate_x           = rate_of(eff_q[SIDE_X]);
  assign o_rate_y           = rate_of(eff_q[SIDE_Y]);
  assign o_engine_in_bit    = in_bit_q;
  assign o_engine_in_valid  = in_val_q;
  assign o_engine_out_req   = out_req_q;
  assign o_engine_ready     = ready_q;
  assign o_standby          = &idle_now;

endmodule

// ---- verification/acc_host_model.sv ----
`timescale 1ns/10ps
module acc_host_model (
  output logic o_sclk,
  output logic o_serial_in,
  output logic o_cs_n
);
  logic [31:0] w;
  initial begin
    o_sclk = 1'b0;
    o_serial_in = 1'b0;
    o_cs_n = 1'b1;
  end
  // In hardware mode the data and select lines double as idle pins.
  task automatic pins(input logic cfg_serial_in, input logic cs);
    o_serial_in = cfg_serial_in;
    o_cs_n = cs;
  endtask
  // The clock stays still between frames; slow stretches every bit.
  task automatic send(input logic [31:0] d, input int nb, input int slow);
    int n;
    w = d & 32'h3F3F_FF7F;
    #3.3;
    o_cs_n = 1'b0;
    for (n = 0; n < 8 * nb; n++) begin
      o_serial_in = w[n];
      #(7.5 * slow);
      o_sclk = 1'b1;
      #(7.5 * slow);
      o_sclk = 1'b0;
    end
    #7.5;
    o_cs_n = 1'b1;
    o_serial_in = ~o_serial_in;
    #100;
  endtask
endmodule

// ---- verification/acc_props.sv ----
`timescale 1ns/10ps
module acc_props #(
  parameter int P_PWRUP_CYCLES = 50
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_cfg_sclk,
  input wire logic       i_cfg_serial_in,
  input wire logic       i_cfg_cs_n,
  input wire logic [5:0] i_dev_addr,
  input wire logic       i_port_mode_strap,
  input wire logic       o_side_x_output_oe,
  input wire logic       o_side_y_output_oe,
  input wire logic [1:0] o_coding_direction,
  input wire logic [1:0] o_law_mu,
  input wire logic [1:0] o_passthru_sel,
  input wire logic [1:0] o_idle_powerdown,
  input wire logic [1:0] o_algo_reinit,
  input wire logic [1:0] o_engine_in_valid,
  input wire logic       o_engine_ready,
  input wire logic       o_standby
);
  localparam int REINIT_MAX = 130;
  localparam int PU_MAX     = P_PWRUP_CYCLES + 10;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  bypass_active_a: assert property (!(o_passthru_sel & o_idle_powerdown))
    else $error("bypass shown on an idle channel");
  idle_tristate_a: assert property (o_idle_powerdown[1] [*3] |-> !o_side_x_output_oe)
    else $error("idle channel still drives its output");
  frame_tristate_a: assert property ((!i_cfg_cs_n && i_port_mode_strap) [*6] |->
    !o_side_x_output_oe && !o_side_y_output_oe)
    else $error("output driven during a register update");
  standby_idle_a: assert property ($stable(o_idle_powerdown) |-> o_standby == &o_idle_powerdown)
    else $error("standby does not follow both idle bits");
  reinit_clear_a: assert property ($rose(o_algo_reinit[1]) |-> ##[1:REINIT_MAX] !o_algo_reinit[1])
    else $error("reinit bit never cleared itself");
  wake_drop_a: assert property ($fell(o_idle_powerdown[1]) |-> ##[0:2] !o_engine_ready)
    else $error("ready kept high on wake");
  powerup_bound_a: assert property (!o_engine_ready && !o_standby |-> ##[1:PU_MAX] o_engine_ready)
    else $error("power-up took too long");
  engine_normal_a: assert property (o_engine_in_valid[1] && $stable(o_passthru_sel[1]) |->
    !o_passthru_sel[1])
    else $error("engine fed while in bypass");
  hw_map_a: assert property ((!i_port_mode_strap && $stable({i_dev_addr, i_cfg_cs_n, i_cfg_serial_in})) [*7]
    |-> o_coding_direction == {i_dev_addr[0], i_dev_addr[3]} && o_law_mu == {i_dev_addr[2], i_dev_addr[5]}
    && o_idle_powerdown == {i_cfg_cs_n, i_cfg_serial_in})
    else $error("hardware pins not mapped");
  hw_clear_a: assert property (!i_port_mode_strap [*7] |-> o_passthru_sel == 2'h0 && o_algo_reinit == 2'h0)
    else $error("register bits not cleared in hardware mode");
  cover property ($rose(o_algo_reinit[1]));
  cover property (o_passthru_sel[1] && o_side_x_output_oe);
  cover property (o_engine_in_valid[1]);
endmodule

bind acc_top acc_props #(.P_PWRUP_CYCLES(P_PWRUP_CYCLES)) acc_props_i (
  .i_sys_clk, .i_rst, .i_cfg_sclk, .i_cfg_serial_in, .i_cfg_cs_n, .i_dev_addr, .i_port_mode_strap,
  .o_side_x_output_oe, .o_side_y_output_oe, .o_coding_direction, .o_law_mu, .o_passthru_sel,
  .o_idle_powerdown, .o_algo_reinit, .o_engine_in_valid, .o_engine_ready, .o_standby);

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
  import acc_pkg::*;
  typedef struct packed {
    logic       side;
    logic [7:0] cr;
    acc_rate_e  rate;
  } acc_row_s;
  localparam logic [5:0] ADDR = 6'h2D;
  logic             i_sys_clk = 1'b0;
  logic             i_rst = 1'b1;
  logic             i_port_mode_strap = 1'b1;
  logic [5:0]       i_dev_addr = ADDR;
  logic             i_side_x_bitclk = 1'b0;
  logic             i_side_x_framesync = 1'b0;
  logic             i_side_x_input = 1'b0;
  logic [1:0]       i_engine_out_bit = 2'h2;
  logic             i_cfg_sclk, i_cfg_serial_in, i_cfg_cs_n;
  logic             o_side_x_output, o_side_x_output_oe, o_side_y_output, o_side_y_output_oe;
  logic [1:0]       o_coding_direction, o_law_mu, o_passthru_sel, o_idle_powerdown, o_algo_reinit;
  logic [1:0]       o_engine_in_bit, o_engine_in_valid, o_engine_out_req;
  acc_rate_e        o_rate_x, o_rate_y;
  logic             o_engine_ready, o_standby;
  int               failures = 0;
  int               tests_run = 0;
  acc_row_s         rows [6] = '{'{1'b1, 8'h00, RATE_32}, '{1'b0, 8'hC7, RATE_24}, '{1'b1, 8'h83, RATE_16},
                                 '{1'b1, 8'h28, RATE_32}, '{1'b0, 8'h4C, RATE_BAD}, '{1'b1, 8'h20, RATE_32}};
  always #4 i_sys_clk = ~i_sys_clk;
  acc_host_model acc_host_model_i (.o_sclk(i_cfg_sclk), .o_serial_in(i_cfg_serial_in), .o_cs_n(i_cfg_cs_n));
  // Both sides share one backplane so that neither side's inputs sit still.
  acc_top #(.P_PWRUP_CYCLES(50)) acc_top_i (
    .i_sys_clk, .i_rst, .i_cfg_sclk, .i_cfg_serial_in, .i_cfg_cs_n, .i_dev_addr, .i_port_mode_strap,
    .i_side_x_bitclk, .i_side_x_framesync, .i_side_x_input, .i_side_y_bitclk(i_side_x_bitclk),
    .i_side_y_framesync(i_side_x_framesync), .i_side_y_input(i_side_x_input), .i_engine_out_bit,
    .o_side_x_output, .o_side_x_output_oe, .o_side_y_output, .o_side_y_output_oe, .o_coding_direction,
    .o_law_mu, .o_passthru_sel, .o_idle_powerdown, .o_algo_reinit, .o_rate_x, .o_rate_y, .o_engine_in_bit,
    .o_engine_in_valid, .o_engine_out_req, .o_engine_ready, .o_standby);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_reset(input logic s, input logic [5:0] a);
    @(negedge i_sys_clk);
    i_rst = 1'b1;
    i_port_mode_strap = s;
    i_dev_addr = a;
    repeat (6) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_sys_clk);
  endtask
  task automatic wr(input logic s, input logic [5:0] a, input logic [23:0] regs, input int nb, input int slow);
    acc_host_model_i.send({regs, 1'b0, s, a}, nb, slow);
    repeat (70) @(negedge i_sys_clk);
  endtask
  // Input slot 1 and output slot 2 of width w; each bit clock half lasts five system cycles.
  task automatic frame(input int w, input logic [7:0] d, input logic look);
    int n;
    i_side_x_framesync = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    for (n = -1; n < 256; n++) begin
      i_side_x_bitclk = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      i_side_x_framesync = 1'b0;
      i_side_x_input = (n >= w && n < 2 * w) ? d[7 - n + w] : ~i_side_x_input;
      repeat (3) @(negedge i_sys_clk);
      i_side_x_bitclk = 1'b0;
      repeat (5) @(negedge i_sys_clk);
      if (look && n >= 2 * w && n < 3 * w) begin
        chk(o_side_x_output_oe, 1'b1);
        chk(o_side_x_output, d[7 - n + 2 * w]);
      end else if (look && n == w) begin
        chk({o_side_x_output_oe, o_side_y_output_oe}, 2'h0);
      end
      if (look && n >= w && n < 2 * w) begin
        chk(o_engine_in_bit[1], d[7 - n + w]);
      end
    end
  endtask
  initial begin
    #500000;
    failures++;
    wrap_up();
  end
  initial begin
    do_reset(1'b1, ADDR);
    chk({o_idle_powerdown, o_standby, o_engine_ready}, 4'hE);
    chk(o_rate_x, RATE_32);
    foreach (rows[i]) begin
      wr(rows[i].side, ADDR, {16'h0, rows[i].cr}, 2, 1 + i % 2);
      chk(o_coding_direction[rows[i].side], rows[i].cr[CR_DIR]);
      chk(o_law_mu[rows[i].side], rows[i].cr[CR_LAW]);
      chk(o_idle_powerdown[rows[i].side], rows[i].cr[CR_IDLE]);
      chk(o_passthru_sel[rows[i].side], rows[i].cr[CR_BYP] & ~rows[i].cr[CR_IDLE]);
      chk(rows[i].side ? o_rate_x : o_rate_y, rows[i].rate);
    end
    for (int j = 0; j < 6; j += 5) begin
      wr(1'b1, ADDR ^ (6'h01 << j), 24'h0, 2, 1);
      chk(o_idle_powerdown[1], 1'b1);
    end
    wr(1'b1, ADDR, 24'h0, 3, 1);
    chk(o_idle_powerdown[1], 1'b1);
    wr(1'b1, ADDR, 24'h10, 2, 1);
    chk(o_algo_reinit[1], 1'b1);
    repeat (60) @(negedge i_sys_clk);
    chk(o_algo_reinit[1], 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(1'b1, ADDR, {16'h0201, 7'h04, k == 0}, 4, 1);
      frame(8 >> k, 8'hA6, 1'b0);
      frame(8 >> k, 8'hA6, 1'b1);
    end
    wr(1'b1, ADDR, 24'h020101, 4, 1);
    frame(8, 8'h00, 1'b0);
    acc_host_model_i.pins(1'b0, 1'b1);
    do_reset(1'b0, ADDR);
    repeat (60) @(negedge i_sys_clk);
    chk({o_coding_direction, o_law_mu, o_idle_powerdown}, 6'h3E);
    chk({o_engine_ready, o_rate_y}, {1'b1, RATE_32});
    do_reset(1'b0, 6'h12);
    chk(o_rate_x, RATE_16);
    do_reset(1'b0, 6'h00);
    repeat (400) @(negedge i_sys_clk);
    i_dev_addr = 6'h12;
    repeat (10) @(negedge i_sys_clk);
    chk(o_rate_y, RATE_24);
    wrap_up();
  end
endmodule
